// >>> common/plf_pkg.sv
/*
 * package for the pid loop limit and feedback stage: scale, field
 * layouts, selector codes, defaults and the carrier structs.
 * assumes every percentage quantity arrives already in the common
 * 0.1 percent signed scale and that a single clock drives the block.
 */
// Overview of operation
// R1: selector 0 clamps between both digital bounds
// R2: selector 1 takes upper bound from input 1
// R3: selector 2 takes lower bound from input 1
// R4: selector 3 adds output to input 1
// R5: feedback select: in2, in1, current, bus voltage
// R6: small error disables the internal ramps
// R7: large error re-enables the internal ramps
// R8: zero threshold keeps ramps always enabled
// R9: display value multiplied by 0.000..50.000 scale
// R10: standby exits once feedback drops below wake level
// R11: policy 0 runs controller whether enabled or not
// R12: policy 1 runs only enabled, restarts at zero
// R13: all quantities share one percent scale
// R14: integrator held at active clamp bound
package plf_pkg;

    // common percent scale: one lsb is 0.1 percent [R13]
    localparam int          PCT_W          = 16;
    localparam int          VIEW_W         = 32;
    localparam logic [15:0] PCT_FULL       = 16'h03E8;  // 100.0 percent
    localparam logic signed [15:0] PCT_MAX = 16'sh7FFF;
    localparam logic signed [15:0] PCT_MIN = -16'sh7FFF;

    // display scale in thousandths, 0.000 .. 50.000
    localparam logic [15:0] VIEW_SCALE_MAX = 16'hC350;  // 50.000
    localparam logic [15:0] VIEW_SCALE_RST = 16'h0000;  // 0.000
    localparam logic [15:0] WAKE_RST       = 16'h0032;  // 5.0 percent
    localparam logic        RESTART_RST    = 1'b1;      // run only when enabled

    // limit scheme codes
    localparam logic [1:0] LIM_DIGITAL  = 2'h0;
    localparam logic [1:0] LIM_UPPER_A1 = 2'h1;
    localparam logic [1:0] LIM_LOWER_A1 = 2'h2;
    localparam logic [1:0] LIM_ADD_A1   = 2'h3;

    // feedback source codes
    localparam logic [1:0] FB_AIN2      = 2'h0;
    localparam logic [1:0] FB_AIN1      = 2'h1;
    localparam logic [1:0] FB_CURRENT   = 2'h2;
    localparam logic [1:0] FB_BUS       = 2'h3;

    typedef logic signed [PCT_W-1:0] plf_pct_t;

    // standby state machine
    typedef enum logic [0:0] {
        PLF_RUN     = 1'b0,
        PLF_STANDBY = 1'b1
    } plf_state_t;

    // software settings, all held steady by the owner
    typedef struct packed {
        logic [1:0]  limit_scheme;
        logic [1:0]  feedback_select;
        plf_pct_t    upper_output_bound_setting;
        plf_pct_t    lower_output_bound_setting;
        logic [15:0] ramp_bypass_threshold;     // 0.1 percent, 0 = off
        logic [15:0] feedback_view_scale;       // thousandths
        logic [15:0] standby_wake_threshold;    // 0.1 percent
        logic        loop_restart_policy;
    } plf_cfg_t;

    // measured quantities, already in percent scale
    typedef struct packed {
        plf_pct_t ain1;
        plf_pct_t ain2;
        plf_pct_t motor_current;
        plf_pct_t dc_bus_voltage;
    } plf_meas_t;

endpackage : plf_pkg

// >>> core/plf_loop.sv
/*
 * pid loop limit and feedback stage: feedback routing, error,
 * integrating output with selectable limits, ramp bypass decision,
 * display scaling, standby wake and restart policy.
 * assumes the gains sit upstream and deliver a per-cycle output step,
 * and that all inputs are synchronous to sys_clk.
 */
module plf_loop (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // settings and measurements
    input  wire plf_pkg::plf_cfg_t  cfg,
    input  wire plf_pkg::plf_meas_t meas,
    input  wire plf_pkg::plf_pct_t  setpoint,
    input  wire plf_pkg::plf_pct_t  ctrl_step,
    // drive side
    input  wire logic              drive_enable,
    input  wire logic              standby_req,
    // results
    output logic signed [15:0]     demand_ff,
    output logic signed [15:0]     error_ff,
    output logic signed [15:0]     feedback_ff,
    output logic signed [31:0]     feedback_view_ff,
    output logic                   ramps_enable_ff,
    output logic                   standby_ff
);
    import plf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // helper functions

    // saturate a 17 bit sum into the percent range
    function automatic plf_pct_t sat17(input logic signed [16:0] v);
        if (v > 17'(PCT_MAX)) begin
            return PCT_MAX;
        end else if (v < 17'(PCT_MIN)) begin
            return PCT_MIN;
        end
        return v[15:0];
    endfunction : sat17

    // clamp between two bounds; lower wins if bounds cross
    function automatic plf_pct_t clamp(input plf_pct_t v, input plf_pct_t lo,
                                       input plf_pct_t hi);
        plf_pct_t r;                // value after the upper bound
        // upper first, lower last, so crossed bounds settle on lo
        r = (v > hi) ? hi : v;
        return (r < lo) ? lo : r;
    endfunction : clamp

    // magnitude, safe because the range is symmetric
    function automatic logic [15:0] mag(input plf_pct_t v);
        return (v < 0) ? 16'(-v) : 16'(v);
    endfunction : mag

    ////////////////////////////////////////////////////////////////////
    // declarations

    plf_pct_t    integ_ff;          // controller integrator
    plf_pct_t    nxt_integ;
    plf_pct_t    nxt_demand;
    plf_pct_t    nxt_error;
    plf_pct_t    nxt_feedback;
    logic signed [31:0] nxt_view;
    logic        nxt_ramps;
    plf_state_t  state_ff;
    plf_state_t  nxt_state;
    plf_pct_t    fb_sel;            // routed feedback, combinational
    plf_pct_t    lo_bound;          // active bounds
    plf_pct_t    hi_bound;
    logic        run_loop;          // controller allowed to integrate
    logic [15:0] view_scale;        // scale limited to its range
    logic [15:0] wake_level;        // wake level limited to 100.0

    ////////////////////////////////////////////////////////////////////
    // feedback routing and bound selection
    always_comb begin
        // route the feedback source
        unique case (cfg.feedback_select)
            FB_AIN2:    fb_sel = meas.ain2;            // [R5]
            FB_AIN1:    fb_sel = meas.ain1;            // [R5]
            FB_CURRENT: fb_sel = meas.motor_current;   // [R5]
            FB_BUS:     fb_sel = meas.dc_bus_voltage;  // [R5]
        endcase
        // all selected bounds are percent values like the output [R13]
        lo_bound = cfg.lower_output_bound_setting;
        hi_bound = cfg.upper_output_bound_setting;
        unique case (cfg.limit_scheme)
            LIM_DIGITAL: begin
                lo_bound = cfg.lower_output_bound_setting;  // [R1]
                hi_bound = cfg.upper_output_bound_setting;  // [R1]
            end
            LIM_UPPER_A1: begin
                hi_bound = meas.ain1;                       // [R2]
            end
            LIM_LOWER_A1: begin
                lo_bound = meas.ain1;                       // [R3]
            end
            LIM_ADD_A1: begin
                // trim mode keeps the digital bounds on the raw output
                lo_bound = cfg.lower_output_bound_setting;
                hi_bound = cfg.upper_output_bound_setting;
            end
        endcase
        // out-of-range settings are limited rather than rejected
        view_scale = (cfg.feedback_view_scale > VIEW_SCALE_MAX) ?
                     VIEW_SCALE_MAX : cfg.feedback_view_scale;
        wake_level = (cfg.standby_wake_threshold > PCT_FULL) ?
                     PCT_FULL : cfg.standby_wake_threshold;
    end

    ////////////////////////////////////////////////////////////////////
    // controller integrator, output, error and ramp decision
    always_comb begin
        // policy 0 integrates always, policy 1 only while enabled
        run_loop = !cfg.loop_restart_policy || drive_enable;  // [R11] [R12]
        nxt_error = sat17(17'(setpoint) - 17'(fb_sel));
        if (!run_loop) begin
            // held at zero so the next enable restarts from zero
            nxt_integ = '0;                                    // [R12]
        end else begin
            // stop at the active bound so no wind-up builds up
            nxt_integ = clamp(sat17(17'(integ_ff) + 17'(ctrl_step)),
                              lo_bound, hi_bound);             // [R14]
        end
        // bounds may move under a held integrator, so clamp again
        nxt_demand = clamp(integ_ff, lo_bound, hi_bound);      // [R1] [R2] [R3]
        if (cfg.limit_scheme == LIM_ADD_A1) begin
            nxt_demand = sat17(17'(nxt_demand) + 17'(meas.ain1));  // [R4]
        end
        // zero threshold disables the bypass; equal error keeps ramps
        if (cfg.ramp_bypass_threshold == 16'h0000) begin
            nxt_ramps = 1'b1;                                  // [R8]
        end else if (mag(nxt_error) < cfg.ramp_bypass_threshold) begin
            nxt_ramps = 1'b0;                                  // [R6]
        end else begin
            nxt_ramps = 1'b1;                                  // [R7]
        end
        nxt_feedback = fb_sel;
        // display only; the loop never reads this product
        // both factors widened first so the product keeps all 32 bits
        nxt_view = 32'(fb_sel) * 32'($signed({1'b0, view_scale}));  // [R9]
    end

    ////////////////////////////////////////////////////////////////////
    // standby state machine
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PLF_RUN: begin
                // entry is accepted under either restart policy
                if (standby_req) begin
                    nxt_state = PLF_STANDBY;
                end
            end
            PLF_STANDBY: begin
                // leave only once the feedback has dropped under the level
                if (fb_sel < $signed({1'b0, wake_level[14:0]})) begin
                    nxt_state = PLF_RUN;                       // [R10]
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            integ_ff         <= '0;
            demand_ff        <= '0;
            error_ff         <= '0;
            feedback_ff      <= '0;
            feedback_view_ff <= '0;
            ramps_enable_ff  <= 1'b1;
            state_ff         <= PLF_RUN;
        end else begin
            integ_ff         <= nxt_integ;
            demand_ff        <= nxt_demand;
            error_ff         <= nxt_error;
            feedback_ff      <= nxt_feedback;
            feedback_view_ff <= nxt_view;
            ramps_enable_ff  <= nxt_ramps;
            state_ff         <= nxt_state;
        end
    end

    assign standby_ff = (state_ff == PLF_STANDBY);

    ////////////////////////////////////////////////////////////////////
    // assertions

    AST_FIXED_CLAMP: assert property (@(posedge sys_clk) disable iff (reset)  // [R1]
        (cfg.limit_scheme == LIM_DIGITAL) ##1 $stable(cfg) |->
        (demand_ff <= cfg.upper_output_bound_setting ||
         cfg.upper_output_bound_setting < cfg.lower_output_bound_setting))
        else $error("demand above upper bound in digital scheme");

    AST_UPPER_FROM_A1: assert property (@(posedge sys_clk) disable iff (reset)  // [R2]
        (cfg.limit_scheme == LIM_UPPER_A1 && integ_ff >= meas.ain1 &&
         meas.ain1 >= cfg.lower_output_bound_setting) |=> demand_ff == $past(meas.ain1))
        else $error("upper bound not taken from analog input 1");

    AST_LOWER_FROM_A1: assert property (@(posedge sys_clk) disable iff (reset)  // [R3]
        (cfg.limit_scheme == LIM_LOWER_A1 && integ_ff < meas.ain1) |=>
        demand_ff == $past(meas.ain1))
        else $error("lower bound not taken from analog input 1");

    AST_ADD_A1: assert property (@(posedge sys_clk) disable iff (reset)  // [R4]
        (cfg.limit_scheme == LIM_ADD_A1 && integ_ff >= lo_bound && integ_ff <= hi_bound &&
         mag(integ_ff) < 16'h4000 && mag(meas.ain1) < 16'h4000) |=>
        demand_ff == $past(integ_ff) + $past(meas.ain1))
        else $error("trim sum is not output plus analog input 1");

    AST_FB_ROUTE: assert property (@(posedge sys_clk) disable iff (reset)  // [R5]
        (cfg.feedback_select == FB_BUS) |=> feedback_ff == $past(meas.dc_bus_voltage))
        else $error("feedback not routed from bus voltage");

    AST_RAMP_BYPASS: assert property (@(posedge sys_clk) disable iff (reset)  // [R6]
        (cfg.ramp_bypass_threshold != 16'h0000 &&
         mag(nxt_error) < cfg.ramp_bypass_threshold) |=> !ramps_enable_ff)
        else $error("ramps left on for a small error");

    AST_RAMP_ON: assert property (@(posedge sys_clk) disable iff (reset)  // [R7]
        (mag(nxt_error) > cfg.ramp_bypass_threshold) |=> ramps_enable_ff)
        else $error("ramps off for a large error");

    AST_RAMP_ZERO: assert property (@(posedge sys_clk) disable iff (reset)  // [R8]
        (cfg.ramp_bypass_threshold == 16'h0000) [*2] |-> ramps_enable_ff)
        else $error("ramps off with zero threshold");

    AST_VIEW_ZERO: assert property (@(posedge sys_clk) disable iff (reset)  // [R9]
        (cfg.feedback_view_scale == 16'h0000) |=> feedback_view_ff == 32'sh0)
        else $error("display nonzero with zero scale");

    AST_WAKE: assert property (@(posedge sys_clk) disable iff (reset)  // [R10]
        (standby_ff && fb_sel >= $signed({1'b0, wake_level[14:0]})) |=> standby_ff)
        else $error("left standby with feedback above wake level");

    AST_RESTART_ZERO: assert property (@(posedge sys_clk) disable iff (reset)  // [R12]
        (cfg.loop_restart_policy && !drive_enable) ##1 drive_enable |->
        integ_ff == 16'sh0000)
        else $error("controller not restarted from zero at enable");

    AST_RUN_DISABLED: assert property (@(posedge sys_clk) disable iff (reset)  // [R11]
        (!cfg.loop_restart_policy && !drive_enable && ctrl_step > 0 &&
         integ_ff >= lo_bound && integ_ff < hi_bound) |=> integ_ff > $past(integ_ff))
        else $error("controller idle while disabled in continuous mode");

    AST_NO_WINDUP: assert property (@(posedge sys_clk) disable iff (reset)  // [R14]
        (run_loop && lo_bound <= hi_bound) |=>
        (integ_ff <= $past(hi_bound) && integ_ff >= $past(lo_bound)))
        else $error("integrator wound past active bound");

    COV_SATURATE: cover property (@(posedge sys_clk) disable iff (reset)
        run_loop && integ_ff == hi_bound ##1 integ_ff == hi_bound);
    COV_BYPASS: cover property (@(posedge sys_clk) disable iff (reset)
        ramps_enable_ff ##1 !ramps_enable_ff);
    COV_WAKE: cover property (@(posedge sys_clk) disable iff (reset)
        standby_ff ##1 !standby_ff);
    COV_TRIM: cover property (@(posedge sys_clk) disable iff (reset)
        cfg.limit_scheme == LIM_ADD_A1 && demand_ff != integ_ff);

endmodule : plf_loop

// >>> bench/plf_far_side.sv
/*
 * far side model: analog inputs, motor current, bus voltage and the
 * speed ramp generator that follows the demand.
 * assumes the bench calls set_meas just after a rising sys_clk edge.
 */
module plf_far_side (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               reset,
    // from the block
    input  wire logic signed [15:0] demand_ff,
    input  wire logic               ramps_enable_ff,
    // to the block
    output plf_pkg::plf_meas_t      meas,
    output logic signed [15:0]      speed_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    import plf_pkg::*;

    // speed change per cycle while ramps are on, small to show the limit
    localparam logic signed [15:0] SLEW = 16'sh0005;

    // levels change only on a clock edge, like a sampled converter
    task automatic set_meas(input plf_pct_t a1, a2, cur, bus);
        meas <= '{a1, a2, cur, bus};
    endtask : set_meas

    ////////////////////////////////////////////////////////////////////
    // ramp generator: jumps to demand when bypassed, else slews
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            speed_ff <= '0;
        end else if (!ramps_enable_ff) begin
            speed_ff <= demand_ff;          // bypassed: no rate limit
        end else if (demand_ff > speed_ff + SLEW) begin
            speed_ff <= speed_ff + SLEW;
        end else if (demand_ff < speed_ff - SLEW) begin
            speed_ff <= speed_ff - SLEW;
        end else begin
            speed_ff <= demand_ff;
        end
    end
endmodule : plf_far_side

// >>> bench/tb.sv
/*
 * self-checking bench for the pid limit and feedback stage.
 * assumes plf_pkg, plf_loop and plf_far_side compiled before it.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import plf_pkg::*;

    logic               sys_clk, reset, drive_enable, standby_req;
    plf_cfg_t           cfg;
    plf_meas_t          meas;
    plf_pct_t           setpoint, ctrl_step;
    logic signed [15:0] demand_ff, error_ff, feedback_ff, speed_ff;
    logic signed [31:0] feedback_view_ff;
    logic               ramps_enable_ff, standby_ff;
    int                 failures, compares;

    plf_loop DUT (.sys_clk(sys_clk), .reset(reset), .cfg(cfg), .meas(meas),
        .setpoint(setpoint), .ctrl_step(ctrl_step), .drive_enable(drive_enable),
        .standby_req(standby_req), .demand_ff(demand_ff), .error_ff(error_ff),
        .feedback_ff(feedback_ff), .feedback_view_ff(feedback_view_ff),
        .ramps_enable_ff(ramps_enable_ff), .standby_ff(standby_ff));
    plf_far_side FAR (.sys_clk(sys_clk), .reset(reset), .demand_ff(demand_ff),
        .ramps_enable_ff(ramps_enable_ff), .meas(meas), .speed_ff(speed_ff));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////
    // helpers: wait edges, compare and count
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic chk(input logic signed [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////////////
    // each source in turn, with display scaling and its upper limit
    task automatic t_feedback;
        plf_pct_t fbv[4] = '{16'sh00DE, 16'sh006F, 16'sh014D, 16'sh01BC};
        cyc(1);
        setpoint <= 16'sh01F4;
        cfg.feedback_view_scale <= 16'h07D0;   // 2.000
        FAR.set_meas(16'sh006F, 16'sh00DE, 16'sh014D, 16'sh01BC);
        for (int s = 0; s < 4; s++) begin
            cyc(1);
            cfg.feedback_select <= 2'(s);
            cyc(3);
            #1;
            chk(feedback_ff, fbv[s], "feedback route");
            chk(error_ff, 16'sh01F4 - fbv[s], "error");
            chk(feedback_view_ff, fbv[s] * 32'sh000007D0, "view");
        end
        cyc(1);
        cfg.feedback_view_scale <= 16'hFFFF;   // beyond range, limited
        cyc(3);
        #1;
        chk(feedback_view_ff, 32'sh0152BEC0, "view limit");
        $display("test feedback done");
    endtask : t_feedback

    ////////////////////////////////////////////////////////////////////
    // every limit scheme, saturated both ways, then pulled off the bound
    task automatic t_limits;
        plf_pct_t hi[4] = '{16'sh012C, 16'sh0064, 16'sh012C, 16'sh0190};
        plf_pct_t lo[4] = '{-16'sh00C8, -16'sh00C8, 16'sh0064, -16'sh0064};
        cyc(1);
        drive_enable <= 1'b0;                  // controller runs anyway
        cfg.loop_restart_policy <= 1'b0;
        FAR.set_meas(16'sh0064, '0, '0, '0);
        for (int s = 0; s < 4; s++) begin
            cyc(1);
            cfg.limit_scheme <= 2'(s);
            ctrl_step <= 16'sh0032;
            cyc(20);
            #1;
            chk(demand_ff, hi[s], "upper bound");
            cyc(1);
            ctrl_step <= -16'sh000A;
            cyc(2);
            #1;
            chk(demand_ff, hi[s] - 16'sh000A, "off upper");
            cyc(1);
            ctrl_step <= -16'sh0032;
            cyc(30);
            #1;
            chk(demand_ff, lo[s], "lower bound");
            cyc(1);
            ctrl_step <= 16'sh000A;
            cyc(2);
            #1;
            chk(demand_ff, lo[s] + 16'sh000A, "off lower");
        end
        $display("test limits done");
    endtask : t_limits

    ////////////////////////////////////////////////////////////////////
    // ramp bypass below threshold, equal keeps ramps, zero threshold
    task automatic t_ramps;
        plf_pct_t   v[4] = '{16'sh0014, 16'sh0050, 16'sh0032, -16'sh0014};
        logic [3:0] e    = 4'h6;
        cyc(1);
        cfg.feedback_select <= FB_AIN2;
        cfg.ramp_bypass_threshold <= 16'h0032;
        setpoint <= '0;
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            FAR.set_meas('0, v[i], '0, '0);
            cyc(4);
            #1;
            chk(ramps_enable_ff, e[i], "ramps");
        end
        cyc(1);
        cfg.ramp_bypass_threshold <= '0;
        FAR.set_meas('0, '0, '0, '0);
        cyc(4);
        #1;
        chk(ramps_enable_ff, 1, "ramps zero threshold");
        $display("test ramps done");
    endtask : t_ramps

    ////////////////////////////////////////////////////////////////////
    // restart policy: held at zero while disabled, restart from zero
    task automatic t_restart;
        cyc(1);
        cfg.limit_scheme <= LIM_DIGITAL;
        cfg.loop_restart_policy <= 1'b1;
        drive_enable <= 1'b0;
        ctrl_step <= 16'sh0032;
        cyc(5);
        #1;
        chk(demand_ff, 0, "held while disabled");
        cyc(1);
        drive_enable <= 1'b1;
        cyc(2);
        #1;
        chk(demand_ff, 16'sh0032, "start from zero");
        cyc(1);
        drive_enable <= 1'b0;
        cfg.loop_restart_policy <= 1'b0;
        cyc(10);
        #1;
        chk(demand_ff, 16'sh012C, "runs while disabled");
        cyc(1);
        cfg.loop_restart_policy <= 1'b1;
        cyc(3);
        #1;
        chk(demand_ff, 0, "cleared by policy");
        $display("test restart done");
    endtask : t_restart

    ////////////////////////////////////////////////////////////////////
    // standby held while feedback is high, left once it drops below
    task automatic t_standby;
        cyc(1);
        cfg.feedback_select <= FB_AIN2;
        cfg.standby_wake_threshold <= WAKE_RST;
        FAR.set_meas('0, 16'sh0064, '0, '0);
        cyc(3);
        standby_req <= 1'b1;
        cyc(1);
        standby_req <= 1'b0;
        #1;
        chk(standby_ff, 1, "standby entry");
        cyc(6);
        #1;
        chk(standby_ff, 1, "standby held");
        cyc(1);
        FAR.set_meas('0, 16'sh001E, '0, '0);
        for (int i = 0; i < 4 && standby_ff !== 1'b0; i++) begin
            cyc(1);
            #1;
        end
        chk(standby_ff, 0, "wake");
        $display("test standby done");
    endtask : t_standby

    task automatic report_and_stop;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////
    // main sequence: defaults, reset, then the scenarios
    initial begin
        failures = 0;
        compares = 0;
        reset = 1'b1;
        drive_enable = 1'b0;
        standby_req = 1'b0;
        setpoint = '0;
        ctrl_step = '0;
        cfg = '0;
        cfg.loop_restart_policy = RESTART_RST;
        cfg.standby_wake_threshold = WAKE_RST;
        cfg.upper_output_bound_setting = 16'sh012C;
        cfg.lower_output_bound_setting = -16'sh00C8;
        FAR.set_meas('0, '0, '0, '0);
        cyc(12);
        chk(demand_ff, 0, "reset demand");
        chk(ramps_enable_ff, 1, "reset ramps");
        reset <= 1'b0;
        t_feedback();
        t_limits();
        t_ramps();
        t_restart();
        t_standby();
        report_and_stop();
    end
endmodule : tb
